// ### logic/trw_sched_end.sv
// Work scheduler input queue plus ring memory end of the link.
// Software side writes slots and pops queued work through plain ports.
`timescale 1ns/100ps
module trw_sched_end #(
  parameter int DEPTH_W = 2
) (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  // Link
  trw_if.sched                               lnk,
  // Software arming and cancelling entries
  input  wire logic                          sw_wr,
  input  wire logic [trw_pkg::ADDR_W-1:0]    sw_addr,
  input  wire logic [trw_pkg::PTR_W-1:0]     sw_wdata,
  // Software receiving work
  input  wire logic                          work_pop,
  output logic                               work_valid,
  output logic [trw_pkg::PTR_W-1:0]          work_ptr
);

  localparam int DEPTH = 1 << trw_pkg::ADDR_W;

  // ****************************************
  // Ring memory
  // ****************************************
  // A software write loses to the walker's clear only on the same word;
  // other words take both writes in one cycle, so no arming is lost.
  logic [trw_pkg::PTR_W-1:0] mem_r [DEPTH];
  logic [trw_pkg::PTR_W-1:0] rdata_r;
  logic                      rvalid_r;

  always_ff @(posedge clock) begin
    if (lnk.mem_wr) begin
      mem_r[lnk.mem_addr] <= lnk.mem_wdata;
    end
    if (sw_wr && !(lnk.mem_wr && sw_addr == lnk.mem_addr)) begin
      mem_r[sw_addr] <= sw_wdata;
    end
    rdata_r <= mem_r[lnk.mem_addr];
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= lnk.mem_rd;
    end
  end

  assign lnk.mem_rdata  = rdata_r;
  assign lnk.mem_rvalid = rvalid_r;

  // ****************************************
  // Scheduler input queue
  // ****************************************
  localparam int QN = 1 << DEPTH_W;
  logic [trw_pkg::PTR_W-1:0] q_r [QN];
  logic [DEPTH_W-1:0]        wp_r;
  logic [DEPTH_W-1:0]        rp_r;
  logic [DEPTH_W:0]          cnt_r;
  logic                      push;
  logic                      pop;

  assign lnk.add_work_ready = (cnt_r != (DEPTH_W+1)'(QN));
  assign push = lnk.add_work_valid && lnk.add_work_ready;
  assign pop  = work_pop && (cnt_r != '0);

  always_ff @(posedge clock) begin
    if (push) begin
      q_r[wp_r] <= lnk.add_work_ptr;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_r + DEPTH_W'(push);
      rp_r  <= rp_r + DEPTH_W'(pop);
      cnt_r <= cnt_r + (DEPTH_W+1)'(push) - (DEPTH_W+1)'(pop);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      work_valid <= 1'b0;
      work_ptr   <= '0;
    end else begin
      work_valid <= (cnt_r + (DEPTH_W+1)'(push) - (DEPTH_W+1)'(pop)) != '0;
      work_ptr   <= (cnt_r == '0 || (pop && cnt_r == 1)) ? lnk.add_work_ptr
                  : (pop ? q_r[rp_r + 1'b1] : q_r[rp_r]);
    end
  end

endmodule

// ### logic/trw_walker.sv
// Timer ring walker: paces sixteen rings, forwards each due slot's live entries
// to the scheduler queue, then zeroes the slot. Memory word address is
// {ring, slot, entry}; one-cycle read latency on the link is assumed.
// Interval and enable are levels, read on every cycle.
`timescale 1ns/100ps

// How it works
// - Sixteen rings, each with own slots.
// - Per-ring interval input paces slot progress.
// - One slot handled per elapsed interval.
// - Each entry pointer other than NULL_PTR or CANCEL_PTR sent as add_work.
// - Slot zeroed after its entries forwarded.
// - Entries fire once, never re-armed.
// - 4 to 5 cycles per entry, short of 80M/s.
// - Software takes and initialises descriptor buffers.
// - Software places pointer at delay slot.
// - Software may cancel before slot processed.
module trw_walker #(
  parameter int RINGS = trw_pkg::RINGS
) (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  // Ring configuration
  input  wire logic [RINGS-1:0]              ring_en,
  input  wire logic [RINGS*trw_pkg::IVL_W-1:0] ring_interval,
  // Status
  output logic                               busy,
  output logic [RINGS*trw_pkg::SLOT_W-1:0]   ring_slot,
  // Link
  trw_if.walker                              lnk
);

  localparam int IW = trw_pkg::IVL_W;
  localparam int SW = trw_pkg::SLOT_W;
  localparam int EW = trw_pkg::ENT_W;
  localparam int RW = trw_pkg::RING_W;
  localparam int AW = trw_pkg::ADDR_W;

  // ****************************************
  // Interval pacing per ring
  // ****************************************
  logic [IW-1:0]    tick_cnt_r [RINGS];
  logic [SW-1:0]    slot_r     [RINGS];
  logic [RINGS-1:0] due_r;
  logic [RINGS-1:0] done_pulse;
  logic [RW-1:0]    cur_ring_r;
  trw_pkg::trw_state_t st_r;
  logic [EW-1:0]    ent_r;

  // Counters run only while enabled; disabling a ring restarts its count
  genvar g;
  generate
    for (g = 0; g < RINGS; g++) begin : g_ring
      // Each ring has an independent counter, slot and due flag
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          tick_cnt_r[g] <= '0;
          due_r[g]      <= 1'b0;
          slot_r[g]     <= '0;
        end else begin
          if (!ring_en[g]) begin
            tick_cnt_r[g] <= '0;
          end else if (tick_cnt_r[g] + 1'b1 >= ring_interval[g*IW +: IW]) begin
            tick_cnt_r[g] <= '0;
          end else begin
            tick_cnt_r[g] <= tick_cnt_r[g] + 1'b1;
          end
          // Set wins over the clear so a tick in the done cycle is not lost
          if (ring_en[g] && tick_cnt_r[g] + 1'b1 >= ring_interval[g*IW +: IW])
          begin
            due_r[g] <= 1'b1;
          end else if (done_pulse[g]) begin
            due_r[g] <= 1'b0;
          end
          if (done_pulse[g]) begin
            slot_r[g] <= slot_r[g] + 1'b1;
          end
        end
      end
      // A slot is done in the CLEAR state of its last entry, before that entry's clear write
      assign done_pulse[g] = (st_r == trw_pkg::TRW_CLEAR) &&
                             (cur_ring_r == RW'(g)) && (ent_r == '1);
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          ring_slot[g*SW +: SW] <= '0;
        end else begin
          ring_slot[g*SW +: SW] <= done_pulse[g] ? slot_r[g] + 1'b1
                                                 : slot_r[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Slot walk
  // ****************************************
  logic [RW-1:0]            pick;
  logic                     any_due;
  logic                     live_ent;

  // A null or cancelled word never reaches the queue
  assign live_ent = lnk.mem_rdata != trw_pkg::NULL_PTR &&
                    lnk.mem_rdata != trw_pkg::CANCEL_PTR;

  // Lowest-numbered due ring first; a slot wait of a few entries is short
  // against any sensible interval, so starvation is not a concern.
  always_comb begin
    pick    = '0;
    any_due = 1'b0;
    for (int i = RINGS - 1; i >= 0; i--) begin
      if (due_r[i]) begin
        pick    = RW'(i);
        any_due = 1'b1;
      end
    end
  end

  logic [trw_pkg::ADDR_W-1:0] addr;
  // Word address is {ring, slot, entry}; the upper bits stay zero
  assign addr = AW'({cur_ring_r, slot_r[cur_ring_r], ent_r});

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r       <= trw_pkg::TRW_IDLE;
      cur_ring_r <= '0;
      ent_r      <= '0;
    end else begin
      case (st_r)
        trw_pkg::TRW_IDLE: begin
          if (any_due) begin
            cur_ring_r <= pick;
            ent_r      <= '0;
            st_r       <= trw_pkg::TRW_READ;
          end
        end
        trw_pkg::TRW_READ: begin
          st_r <= trw_pkg::TRW_WAIT;
        end
        trw_pkg::TRW_WAIT: begin
          // Read data stands one cycle after the strobe; deciding on the
          // strobe's own edge would act on the previous word
          if (lnk.mem_rvalid) begin
            if (live_ent) begin
              st_r <= trw_pkg::TRW_SUBMIT;
            end else begin
              st_r <= trw_pkg::TRW_CLEAR;
            end
          end
        end
        trw_pkg::TRW_SUBMIT: begin
          // Hold until the queue has room; dropping it would lose a timer
          if (lnk.add_work_ready) begin
            st_r <= trw_pkg::TRW_CLEAR;
          end
        end
        trw_pkg::TRW_CLEAR: begin
          // Each entry is zeroed as it goes, so it can never fire again
          ent_r <= ent_r + 1'b1;
          st_r  <= (ent_r == '1) ? trw_pkg::TRW_IDLE : trw_pkg::TRW_READ;
        end
        default: begin
          st_r <= trw_pkg::TRW_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Link outputs
  // ****************************************
  // Registered link outputs follow the state one cycle behind the
  // decision, so each entry costs a few cycles and the unit stays below
  // the 80 M/s target at 100 MHz; a pipelined read path would close that
  // gap, traded here for a simple registered design.
  // Address is captured on the decision edge, so it stands through the
  // whole read or write.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lnk.mem_rd         <= 1'b0;
      lnk.mem_wr         <= 1'b0;
      lnk.mem_addr       <= '0;
      lnk.mem_wdata      <= '0;
      lnk.add_work_valid <= 1'b0;
      lnk.add_work_ptr   <= '0;
      busy               <= 1'b0;
    end else begin
      lnk.mem_rd    <= 1'b0;
      lnk.mem_wr    <= 1'b0;
      lnk.mem_wdata <= trw_pkg::NULL_PTR;
      busy          <= (st_r != trw_pkg::TRW_IDLE) || any_due;
      if (st_r == trw_pkg::TRW_READ) begin
        lnk.mem_rd   <= 1'b1;
        lnk.mem_addr <= addr;
      end
      if (st_r == trw_pkg::TRW_CLEAR) begin
        lnk.mem_wr   <= 1'b1;
        lnk.mem_addr <= addr;
      end
      if (st_r == trw_pkg::TRW_WAIT && lnk.mem_rvalid && live_ent) begin
        lnk.add_work_valid <= 1'b1;
        lnk.add_work_ptr   <= lnk.mem_rdata;
      end else if (lnk.add_work_valid && lnk.add_work_ready) begin
        lnk.add_work_valid <= 1'b0;
      end
    end
  end

endmodule

// ### pkg/trw_if.sv
// Link between the ring walker and the work scheduler / ring memory end.
// Memory read has one-cycle latency; writes complete in the same cycle.
`timescale 1ns/100ps
interface trw_if;
  logic                          mem_rd;
  logic                          mem_wr;
  logic [trw_pkg::ADDR_W-1:0]    mem_addr;
  logic [trw_pkg::PTR_W-1:0]     mem_wdata;
  logic [trw_pkg::PTR_W-1:0]     mem_rdata;
  logic                          mem_rvalid;
  logic                          add_work_valid;
  logic [trw_pkg::PTR_W-1:0]     add_work_ptr;
  logic                          add_work_ready;

  modport walker (
    output mem_rd, mem_wr, mem_addr, mem_wdata, add_work_valid, add_work_ptr,
    input  mem_rdata, mem_rvalid, add_work_ready
  );
  modport sched (
    input  mem_rd, mem_wr, mem_addr, mem_wdata, add_work_valid, add_work_ptr,
    output mem_rdata, mem_rvalid, add_work_ready
  );
endinterface

// ### pkg/trw_pkg.sv
// Shared constants and types for the timer ring walker and its partner.
// Assumes one core clock; memory words are descriptor pointers.
package trw_pkg;

  // ****************************************
  // Geometry and timing
  // ****************************************
  localparam int RINGS      = 16;
  localparam int RING_W     = 4;
  localparam int PTR_W      = 32;
  localparam int ADDR_W     = 16;
  localparam int SLOT_W     = 4;
  localparam int ENT_W      = 3;
  localparam int IVL_W      = 16;
  localparam int CLK_MHZ    = 100;
  localparam int ENT_RATE_M = 80;
  // Cycles per entry at the 80 M/s target; one entry per cycle beats it
  localparam int ENT_CYC    = (CLK_MHZ + ENT_RATE_M - 1) / ENT_RATE_M;
  localparam logic [PTR_W-1:0] NULL_PTR = 32'h0000_0000;
  localparam logic [PTR_W-1:0] CANCEL_PTR = 32'hFFFF_FFFF;

  // ****************************************
  // Walker states
  // ****************************************
  typedef enum logic [2:0] {
    TRW_IDLE,
    TRW_READ,
    TRW_WAIT,
    TRW_SUBMIT,
    TRW_CLEAR
  } trw_state_t;

endpackage

// ### tb/test_timer_ring_walker.sv
// Bench for walker and scheduler end joined by the link interface.
// Assumes the package and interface are compiled first.
`timescale 1ns/100ps
module test_timer_ring_walker;
  localparam int IVL = 100;
  logic                                     clock;
  logic                                     sys_rst;
  logic [trw_pkg::RINGS-1:0]                ring_en;
  logic [trw_pkg::RINGS*trw_pkg::IVL_W-1:0] ring_interval;
  logic                                     busy;
  logic [trw_pkg::RINGS*trw_pkg::SLOT_W-1:0] ring_slot;
  logic                                     sw_wr;
  logic [trw_pkg::ADDR_W-1:0]               sw_addr;
  logic [trw_pkg::PTR_W-1:0]                sw_wdata;
  logic                                     work_pop;
  logic                                     work_valid;
  logic [trw_pkg::PTR_W-1:0]                work_ptr;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  int t_last = 0;
  int t_first = 0;
  trw_if lnk_if ();
  trw_walker i_trw_walker (.clock(clock), .sys_rst(sys_rst),
    .ring_en(ring_en), .ring_interval(ring_interval), .busy(busy),
    .ring_slot(ring_slot), .lnk(lnk_if));
  trw_sched_end i_trw_sched_end (.clock(clock), .sys_rst(sys_rst),
    .lnk(lnk_if), .sw_wr(sw_wr), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .work_pop(work_pop), .work_valid(work_valid), .work_ptr(work_ptr));
  trw_monitor i_trw_monitor (.clock(clock), .sys_rst(sys_rst),
    .mem_rd(lnk_if.mem_rd), .mem_wr(lnk_if.mem_wr),
    .mem_addr(lnk_if.mem_addr), .mem_wdata(lnk_if.mem_wdata),
    .mem_rdata(lnk_if.mem_rdata), .mem_rvalid(lnk_if.mem_rvalid),
    .add_work_valid(lnk_if.add_work_valid),
    .add_work_ptr(lnk_if.add_work_ptr),
    .add_work_ready(lnk_if.add_work_ready));
  // ****************************************
  // Clock and tasks
  // ****************************************
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check_val(input string what, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Leaves the strobe high so writes run back to back; caller drops it
  task automatic sw_put(input int r, s, e, input logic [31:0] ptr);
    @(posedge clock);
    sw_wr <= 1'h1;
    sw_addr <= {5'h00, r[3:0], s[3:0], e[2:0]};
    sw_wdata <= ptr;
  endtask
  task automatic take_work(input logic [31:0] exp);
    int n;
    n = 0;
    do @(posedge clock);
    while (work_valid !== 1'h1 && ++n < 4000);
    if (n >= 4000) begin
      n_errors++;
      report_and_stop();
    end
    check_val("work_ptr", exp, work_ptr);
    t_last = cyc;
    work_pop <= 1'h1;
    @(posedge clock);
    work_pop <= 1'h0;
  endtask
  // Waits for the walker to go quiet; a hang counts as a mismatch
  task automatic wait_idle();
    int n;
    n = 0;
    do @(posedge clock);
    while (busy !== 1'h0 && ++n < 400);
    if (n >= 400) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sys_rst = 1'h1;
    ring_en = '0;
    ring_interval = '0;
    sw_wr = 1'h0;
    sw_addr = '0;
    sw_wdata = '0;
    work_pop = 1'h0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'h0;
    @(posedge clock);
    check_val("busy", 32'h0, 32'(busy));
    check_val("slots", 32'h1, 32'(ring_slot === '0));
    // Memory is not reset, so every slot of both rings is emptied first
    for (int i = 0; i < 256; i++)
      sw_put(i < 128 ? 0 : 5, i[6:3], i[2:0], trw_pkg::NULL_PTR);
    sw_put(0, 0, 0, 32'h0000_1000);
    sw_put(0, 0, 2, trw_pkg::CANCEL_PTR);
    sw_put(0, 0, 7, 32'h0000_2000);
    sw_put(0, 1, 5, 32'h0000_6000);
    sw_put(0, 1, 5, trw_pkg::CANCEL_PTR);
    sw_put(0, 1, 3, 32'h0000_3000);
    sw_put(0, 15, 0, 32'h0000_4000);
    sw_put(5, 0, 4, 32'h0000_5000);
    @(posedge clock);
    sw_wr <= 1'h0;
    ring_interval[0 +: 16] <= 16'(IVL);
    ring_interval[80 +: 16] <= 16'(IVL);
    ring_en <= 16'h0021;
    take_work(32'h0000_1000);
    t_first = t_last;
    take_work(32'h0000_2000);
    take_work(32'h0000_5000);
    take_work(32'h0000_3000);
    take_work(32'h0000_4000);
    check_val("pace", 32'h1, 32'(t_last - t_first >= 15 * IVL - 2 &&
      t_last - t_first <= 15 * IVL + 2));
    check_val("busy", 32'h1, 32'(busy));
    wait_idle();
    check_val("slot0", 32'h0, 32'(ring_slot[3:0]));
    check_val("slot5", 32'h0, 32'(ring_slot[23:20]));
    // A full second lap must find every slot already cleared
    repeat (17 * IVL) @(posedge clock);
    check_val("spurious", 32'h0, 32'(work_valid));
    report_and_stop();
  end
endmodule

// ### tb/trw_monitor.sv
// Checker for the link between ring walker and scheduler end.
// Assumes one clock; placed beside the link interface.
`timescale 1ns/100ps
module trw_monitor (
  // Clock and reset
  input wire logic                       clock,
  input wire logic                       sys_rst,
  // Link
  input wire logic                       mem_rd,
  input wire logic                       mem_wr,
  input wire logic [trw_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [trw_pkg::PTR_W-1:0]  mem_wdata,
  input wire logic [trw_pkg::PTR_W-1:0]  mem_rdata,
  input wire logic                       mem_rvalid,
  input wire logic                       add_work_valid,
  input wire logic [trw_pkg::PTR_W-1:0]  add_work_ptr,
  input wire logic                       add_work_ready
);
  // ****************************************
  // Last read address
  // ****************************************
  logic [trw_pkg::ADDR_W-1:0] rd_addr_r;
  logic                       rd_seen_r;
  logic                       live;
  assign live = mem_rdata != trw_pkg::NULL_PTR &&
                mem_rdata != trw_pkg::CANCEL_PTR;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_addr_r <= 16'h0000;
      rd_seen_r <= 1'h0;
    end else if (mem_rd) begin
      rd_addr_r <= mem_addr;
      rd_seen_r <= 1'h1;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  chk_rd_pulse: assert property (mem_rd |=> !mem_rd && mem_rvalid)
    else $error("read strobe or read answer wrong");
  chk_work_fwd: assert property (mem_rvalid && live |=>
    add_work_valid && add_work_ptr == $past(mem_rdata))
    else $error("entry pointer not forwarded");
  chk_skip_dead: assert property (mem_rvalid && !live |=>
    !add_work_valid) else $error("dead entry forwarded");
  chk_work_hold: assert property (add_work_valid && !add_work_ready
    |=> add_work_valid && $stable(add_work_ptr))
    else $error("work request dropped early");
  chk_clear_zero: assert property (mem_wr |->
    mem_wdata == trw_pkg::NULL_PTR && mem_addr == rd_addr_r)
    else $error("clear wrote wrong word");
  chk_clear_due: assert property (mem_rd |-> ##[2:40] mem_wr)
    else $error("entry not cleared in time");
  chk_entry_order: assert property (mem_rd && rd_seen_r &&
    rd_addr_r[2:0] != 3'h7 |-> mem_addr == rd_addr_r + 16'h0001)
    else $error("entries read out of order");
  chk_slot_start: assert property (mem_rd && rd_seen_r &&
    rd_addr_r[2:0] == 3'h7 |-> mem_addr[2:0] == 3'h0)
    else $error("slot not started at first entry");
endmodule
